// File: hdl/dual_channel_pwm_unit.sv
/*
  Two-channel PWM unit with an AXI4-Lite register slave.
  Each channel has a control byte and a 16-bit width register; a status
  word shows which channels run and their output levels.
  Assumes one 100 MHz clock, synchronous active-low reset, and a
  master with at most one write and one read outstanding.
*/
`timescale 1ns/1ps
module dual_channel_pwm_unit
  import pwm_pkg::*;
(
  // clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // write address channel
  input  wire logic [31:0]   s_axi_awaddr,
  input  wire logic [2:0]    s_axi_awprot,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  // write data channel
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  // write response channel
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  // read address channel
  input  wire logic [31:0]   s_axi_araddr,
  input  wire logic [2:0]    s_axi_arprot,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  // read data channel
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  // pwm pins, one per channel
  output logic [CHANNELS-1:0] pwm_out
);

  function automatic logic [2:0] reg_select(input logic [31:0] addr);
    logic [2:0] s;
    case (addr)
      CTRL0_ADDR:  s = SEL_CTRL0;
      WIDTH0_ADDR: s = SEL_WIDTH0;
      CTRL1_ADDR:  s = SEL_CTRL1;
      WIDTH1_ADDR: s = SEL_WIDTH1;
      STATUS_ADDR: s = SEL_STATUS;
      default:     s = SEL_NONE;
    endcase
    return s;
  endfunction

  // merge a write into a stored value one byte lane at a time
  function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                             input logic [15:0] data,
                                             input logic [1:0]  strb);
    logic [15:0] r;
    r = old;
    if (strb[0]) begin
      r[7:0] = data[7:0];
    end
    if (strb[1]) begin
      r[15:8] = data[15:8];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // register storage

  logic [7:0]  control [CHANNELS];
  logic [15:0] width   [CHANNELS];
  logic [CHANNELS-1:0] running;

  ////////////////////////////////////////////////////////////////////////
  // write path: address and data may arrive in either order

  logic        aw_held;
  logic        w_held;
  logic [31:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire  = s_axi_wvalid && s_axi_wready;
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire [2:0] wsel = reg_select(aw_addr);
  wire wr_hit = (wsel != SEL_NONE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      aw_addr       <= '0;
      s_axi_awready <= 1'b0;
    end else begin
      if (aw_fire) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      s_axi_awready <= !aw_held && !aw_fire && !do_write;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held       <= 1'b0;
      w_data       <= '0;
      w_strb       <= '0;
      s_axi_wready <= 1'b0;
    end else begin
      if (w_fire) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
      s_axi_wready <= !w_held && !w_fire && !do_write;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-channel registers and pulse logic

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
      wire [2:0] ctrl_sel  = (ch == 1) ? SEL_CTRL1  : SEL_CTRL0;
      wire [2:0] width_sel = (ch == 1) ? SEL_WIDTH1 : SEL_WIDTH0;
      wire ctrl_wr  = do_write && (wsel == ctrl_sel) && w_strb[0];
      wire width_wr = do_write && (wsel == width_sel);
      wire tick;

      // byte lane 0 holds the whole control byte; bit updates are
      // read-modify-write by software
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          control[ch] <= CTRL_RESET;
        end else if (ctrl_wr) begin
          control[ch] <= w_data[7:0];
        end
      end

      // each byte lane updates only its own half
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          width[ch] <= WIDTH_RESET;
        end else if (width_wr) begin
          width[ch] <= lane_merge(width[ch], w_data[15:0],
                                  w_strb[1:0]);
        end
      end

      pwm_prescaler u_prescaler (
        .aclk    (aclk),
        .aresetn (aresetn),
        .run     (control[ch][RUN_BIT]),
        .div_sel (control[ch][DIV_HI:DIV_LO]),
        .tick    (tick)
      );

      pwm_channel u_channel (
        .aclk    (aclk),
        .aresetn (aresetn),
        .control (control[ch]),
        .width   (width[ch]),
        .tick    (tick),
        .pwm_out (pwm_out[ch]),
        .running (running[ch])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // read path: one cycle from address handshake to data

  wire ar_fire = s_axi_arvalid && s_axi_arready;
  wire [2:0] rsel = reg_select(s_axi_araddr);
  logic [31:0] status_word;
  logic [31:0] read_word;

  always_comb begin
    status_word = '0;
    status_word[STAT_RUN_LO +: CHANNELS] = running;
    status_word[STAT_OUT_LO +: CHANNELS] = pwm_out;
  end

  always_comb begin
    case (rsel)
      SEL_CTRL0:  read_word = {24'h000000, control[0]};
      SEL_WIDTH0: read_word = {16'h0000, width[0]};
      SEL_CTRL1:  read_word = {24'h000000, control[1]};
      SEL_WIDTH1: read_word = {16'h0000, width[1]};
      SEL_STATUS: read_word = status_word;
      default:    read_word = '0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      if (ar_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= read_word;
        s_axi_rresp  <= (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_rvalid && !ar_fire;
    end
  end

endmodule

// File: shared/pwm_pkg.sv
/*
  Shared constants for the two-channel PWM unit: register map, control
  field positions, reset values, prescaler limits and channel states.
  Assumes a 32-bit AXI4-Lite register bus and one 100 MHz clock.
*/
package pwm_pkg;

  localparam int CHANNELS = 2;

  // register byte addresses
  localparam logic [31:0] CTRL0_ADDR  = 32'hfffffb00;
  localparam logic [31:0] WIDTH0_ADDR = 32'hfffffb04;
  localparam logic [31:0] CTRL1_ADDR  = 32'hfffffb10;
  localparam logic [31:0] WIDTH1_ADDR = 32'hfffffb14;
  localparam logic [31:0] STATUS_ADDR = 32'hfffffb20;

  // decoded register selectors
  localparam logic [2:0] SEL_CTRL0  = 3'h0;
  localparam logic [2:0] SEL_WIDTH0 = 3'h1;
  localparam logic [2:0] SEL_CTRL1  = 3'h2;
  localparam logic [2:0] SEL_WIDTH1 = 3'h3;
  localparam logic [2:0] SEL_STATUS = 3'h4;
  localparam logic [2:0] SEL_NONE   = 3'h7;

  // control register layout and reset
  localparam logic [7:0] CTRL_RESET  = 8'h08;
  localparam logic [15:0] WIDTH_RESET = 16'h0000;
  localparam int RUN_BIT  = 7;
  localparam int LEN_HI   = 6;
  localparam int LEN_LO   = 4;
  localparam int POL_BIT  = 3;
  localparam int SYNC_BIT = 2;
  localparam int DIV_HI   = 1;
  localparam int DIV_LO   = 0;

  // main pulse length: code 0 is 8 bits, each step one bit fewer
  localparam logic [2:0] LEN_MAX_CODE  = 3'h4;
  localparam logic [3:0] MAIN_BITS_MAX = 4'h8;

  // prescaler: divide by 4 shifted left by the select code
  localparam logic [5:0] DIV_MIN = 6'h04;

  // status register layout
  localparam int STAT_RUN_LO = 0;
  localparam int STAT_OUT_LO = 4;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN  = 3'b100
  } chan_state_e;

endpackage

// File: hdl/pwm_prescaler.sv
/*
  Prescaler for one PWM channel: a one-cycle tick every 4, 8, 16 or 32
  clocks. Assumes the select code is stable while the channel runs.
*/
`timescale 1ns/1ps
module pwm_prescaler
  import pwm_pkg::*;
(
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // control
  input  wire logic       run,
  input  wire logic [1:0] div_sel,
  // operating clock tick
  output logic            tick
);

  logic [5:0] count;
  wire  [5:0] limit   = (DIV_MIN << div_sel) - 6'h01;
  wire        at_end  = (count == limit);

  ////////////////////////////////////////////////////////////////////////
  // held at zero while stopped so every start has the same phase
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      count <= '0;
      tick  <= 1'b0;
    end else begin
      count <= at_end ? '0 : count + 6'h01;
      tick  <= at_end;
    end
  end

endmodule

// File: hdl/pwm_channel.sv
/*
  One PWM channel: reload controller, main and ancillary pulse
  generators and the pulse synthesiser. Assumes control and width come
  straight from software registers and tick from its prescaler.
*/
`timescale 1ns/1ps
module pwm_channel
  import pwm_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // software settings
  input  wire logic [7:0]  control,
  input  wire logic [15:0] width,
  // operating clock tick
  input  wire logic        tick,
  // output and state
  output logic             pwm_out,
  output logic             running
);

  function automatic logic [7:0] bit_rev(input logic [7:0] v);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction

  chan_state_e state;
  chan_state_e next_state;
  logic [7:0]  cnt;
  logic [7:0]  frame;
  logic [7:0]  main_w;
  logic [7:0]  anc_n;

  wire       run  = control[RUN_BIT];
  wire [2:0] len  = control[LEN_HI:LEN_LO];
  wire       pol  = control[POL_BIT];
  wire       sync = control[SYNC_BIT];

  // prohibited codes fall back to the longest length
  wire [3:0] main_bits = (len > LEN_MAX_CODE) ? MAIN_BITS_MAX
                         : MAIN_BITS_MAX - {1'b0, len};
  wire [7:0] mask      = 8'hff >> (MAIN_BITS_MAX - main_bits);
  wire cycle_end = tick && (cnt == mask);
  wire frame_end = cycle_end && (frame == 8'hff);
  wire reload    = sync ? cycle_end : frame_end;

  // ancillary slots in bit-reversed order spread evenly over the frame
  wire anc_on   = (bit_rev(frame) < anc_n);
  wire main_act = (cnt < main_w);
  wire anc_act  = anc_on && (cnt == main_w);
  wire act      = main_act || anc_act;
  wire live     = (state == ST_RUN) && run;
  // inactive level follows polarity at once, running or not
  wire next_out = live ? (pol ? act : ~act) : ~pol;

  always_comb begin
    case (state)
      ST_IDLE: next_state = run ? ST_WAIT : ST_IDLE;
      ST_WAIT: next_state = !run ? ST_IDLE
                            : (reload ? ST_RUN : ST_WAIT);
      ST_RUN:  next_state = run ? ST_RUN : ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state   <= ST_IDLE;
      pwm_out <= 1'b0;
      running <= 1'b0;
    end else begin
      state   <= next_state;
      pwm_out <= next_out;
      running <= (next_state == ST_RUN);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      cnt   <= '0;
      frame <= '0;
    end else if (tick) begin
      cnt   <= cycle_end ? '0 : cnt + 8'h01;
      frame <= cycle_end ? frame + 8'h01 : frame;
    end
  end

  // working copies change only on the reload signal
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      main_w <= '0;
      anc_n  <= '0;
    end else if (run && reload) begin
      main_w <= width[15:8] & mask;
      anc_n  <= width[7:0];
    end
  end

endmodule

// File: tb/pwm_unit_props.sv
/*
  Checker for dual_channel_pwm_unit: bus answers and stopped pin level.
  Assumes write address and data are offered together, one of each at a time.
*/
`timescale 1ns/1ps
module pwm_unit_props
  import pwm_pkg::*;
(
  // clock and reset
  input wire logic                aclk,
  input wire logic                aresetn,
  // register bus
  input wire logic [31:0]         s_axi_awaddr,
  input wire logic                s_axi_awvalid,
  input wire logic                s_axi_awready,
  input wire logic [31:0]         s_axi_wdata,
  input wire logic [3:0]          s_axi_wstrb,
  input wire logic                s_axi_wvalid,
  input wire logic                s_axi_wready,
  input wire logic [1:0]          s_axi_bresp,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  input wire logic [31:0]         s_axi_araddr,
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_arready,
  input wire logic [1:0]          s_axi_rresp,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready,
  // pins
  input wire logic [CHANNELS-1:0] pwm_out
);
  logic [31:0] aw_q;
  logic [31:0] w_q;
  logic        s0_q;
  logic        bv_q;
  logic [7:0]  ctl [CHANNELS];
  wire         wr_done = s_axi_bvalid & ~bv_q;
  wire         q_map = aw_q inside {CTRL0_ADDR, WIDTH0_ADDR, CTRL1_ADDR,
                                    WIDTH1_ADDR, STATUS_ADDR};
  wire         ar_map = s_axi_araddr inside {CTRL0_ADDR, WIDTH0_ADDR,
                                    CTRL1_ADDR, WIDTH1_ADDR, STATUS_ADDR};

  // shadow control bytes, taken when the response first shows
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bv_q <= 1'b0;
      ctl  <= '{default: CTRL_RESET};
    end else begin
      bv_q <= s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) w_q <= s_axi_wdata;
      if (s_axi_wvalid && s_axi_wready) s0_q <= s_axi_wstrb[0];
      for (int n = 0; n < CHANNELS; n++)
        if (wr_done && s0_q && aw_q == (n ? CTRL1_ADDR : CTRL0_ADDR))
          ctl[n] <= w_q[7:0];
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_b_late;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence

  property p_reset;
    $rose(aresetn) |-> pwm_out == '0 && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  property p_b_answer;
    s_wr_take |=> s_b_late;
  endproperty
  property p_w_resp;
    s_wr_take |-> ##2 s_axi_bresp == (q_map ? RESP_OKAY : RESP_SLVERR);
  endproperty
  property p_b_once;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  property p_r_answer;
    s_rd_take |=> s_axi_rvalid;
  endproperty
  property p_r_resp;
    s_rd_take |=> s_axi_rresp == ($past(ar_map) ? RESP_OKAY : RESP_SLVERR);
  endproperty
  property p_r_once;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  property p_stop0;
    !ctl[0][RUN_BIT] |-> pwm_out[0] == ~ctl[0][POL_BIT];
  endproperty
  property p_stop1;
    !ctl[1][RUN_BIT] |-> pwm_out[1] == ~ctl[1][POL_BIT];
  endproperty

  a_reset: assert property (p_reset)
    else $error("pin or response active after reset");
  a_b_answer: assert property (p_b_answer)
    else $error("write response late or early");
  a_w_resp: assert property (p_w_resp)
    else $error("write response code wrong");
  a_b_once: assert property (p_b_once)
    else $error("write response held after acceptance");
  a_r_answer: assert property (p_r_answer)
    else $error("read data late");
  a_r_resp: assert property (p_r_resp)
    else $error("read response code wrong");
  a_r_once: assert property (p_r_once)
    else $error("read data held after acceptance");
  a_ar_block: assert property (p_ar_block)
    else $error("read address taken while data pending");
  a_stop0: assert property (p_stop0)
    else $error("stopped channel 0 pin not inactive");
  a_stop1: assert property (p_stop1)
    else $error("stopped channel 1 pin not inactive");
endmodule

// File: tb/lp_filter_model.sv
/*
  Far side: an integrating filter on each pwm pin, counting high clocks.
  Assumes clear comes from the bench.
*/
`timescale 1ns/1ps
module lp_filter_model
  import pwm_pkg::*;
(
  // clock and control
  input  wire logic                aclk,
  input  wire logic                clear,
  // pins from the unit
  input  wire logic [CHANNELS-1:0] pin,
  // integrated level
  output int                       high_clocks [CHANNELS]
);
  // a pin sampled at an edge stands for the whole clock before it
  always @(posedge aclk)
    for (int n = 0; n < CHANNELS; n++)
      high_clocks[n] <= clear ? 0 : high_clocks[n] + int'(pin[n]);
endmodule

// File: tb/tb_top.sv
/*
  Testbench for dual_channel_pwm_unit: registers, duty, frame, start delay.
  Assumes the package, checker and filter model are compiled first.
*/
`timescale 1ns/1ps
module tb_top
  import pwm_pkg::*;
;
  localparam logic [31:0] MAP [5] = '{CTRL0_ADDR, WIDTH0_ADDR, CTRL1_ADDR,
                                      WIDTH1_ADDR, STATUS_ADDR};
  logic                aclk = 1'b0;
  logic                aresetn = 1'b0;
  logic                clear = 1'b0;
  logic [31:0]         s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
  logic [31:0]         s_axi_araddr = 32'h0;
  logic [3:0]          s_axi_wstrb = 4'h0;
  logic                s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic                s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic                s_axi_rready = 1'b0;
  logic                s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic                s_axi_arready, s_axi_rvalid;
  logic [1:0]          s_axi_bresp, s_axi_rresp;
  logic [31:0]         s_axi_rdata;
  logic [CHANNELS-1:0] pwm_out;
  int                  high_clocks [CHANNELS];
  int                  compares = 0, miscompares = 0;
  logic [7:0]          ctl_m [CHANNELS];
  logic [15:0]         wid_m [CHANNELS];

  always #5 aclk = ~aclk;

  dual_channel_pwm_unit i_dual_channel_pwm_unit (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pwm_out);
  lp_filter_model i_lp_filter_model (.aclk, .clear, .pin(pwm_out),
                                     .high_clocks);
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    logic ok;
    int   n;
    ok = (a inside {MAP}) && !a[5];
    n = a[4];
    if (ok && !a[2] && s[0]) ctl_m[n] = d[7:0];
    if (ok && a[2] && s[0]) wid_m[n][7:0] = d[7:0];
    if (ok && a[2] && s[1]) wid_m[n][15:8] = d[15:8];
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, (a inside {MAP}) ? 32'h0 : 32'h2);
    // one edge between transfers so bready is never driven twice at once
    @(posedge aclk);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp,
                    input logic [1:0] resp);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, exp);
    chk({30'h0, s_axi_rresp}, {30'h0, resp});
    @(posedge aclk);
  endtask

  // status expectation holds only while both channels are stopped
  task automatic rdm(input logic [31:0] a);
    logic [31:0] e;
    int          n;
    n = a[4];
    e = a[2] ? 32'(wid_m[n]) : 32'(ctl_m[n]);
    if (a == STATUS_ADDR)
      e = {26'h0, ~ctl_m[1][POL_BIT], ~ctl_m[0][POL_BIT], 4'h0};
    rd(a, e, RESP_OKAY);
  endtask

  task automatic pinchk(input int n);
    @(posedge aclk);
    chk({31'h0, pwm_out[n]}, {31'h0, ~ctl_m[n][POL_BIT]});
  endtask

  task automatic measure(input int n, input int len, input int exp);
    clear <= 1'b1;
    @(posedge aclk);
    clear <= 1'b0;
    repeat (len) @(posedge aclk);
    #1;
    chk(32'(high_clocks[n]), 32'(exp));
    @(posedge aclk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] h;
    logic [7:0] l;
    logic [7:0] c;
    int         per;
    int         act;
    int         n;
    void'($urandom(32'h033d));
    for (int i = 0; i < CHANNELS; i++) begin
      ctl_m[i] = CTRL_RESET;
      wid_m[i] = WIDTH_RESET;
    end
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({30'h0, pwm_out}, 32'h0);
    for (int i = 0; i < 5; i++) rdm(MAP[i]);
    rd(32'hfffffb08, 32'h0, RESP_SLVERR);
    wr(32'hfffffb0c, $urandom, 4'hf);
    wr(STATUS_ADDR, $urandom, 4'hf);
    for (n = 0; n < CHANNELS; n++) begin
      wr(MAP[2*n+1], $urandom, 4'h1);
      wr(MAP[2*n+1], $urandom, 4'h2);
      rdm(MAP[2*n+1]);
      wr(MAP[2*n], $urandom & 32'h3f, 4'h1);
      rdm(MAP[2*n]);
      pinchk(n);
      // single-bit access as read-modify-write of the byte
      wr(MAP[2*n], {24'h0, ctl_m[n] ^ 8'h08}, 4'h1);
      pinchk(n);
      wr(MAP[2*n], 32'h80, 4'h2);
      rdm(MAP[2*n]);
    end
    // every allowed length code (0 to 4), every divider, one active-low pass, one zero width
    for (int code = 0; code <= LEN_MAX_CODE; code++) begin
      n = code % CHANNELS;
      per = (256 >> code) * (4 << (code % 4));
      h = (code == 4) ? 8'h00 : 8'($urandom);
      c = {1'b1, 3'(code), code != 1, 1'b1, 2'(code % 4)};
      act = (h & ((256 >> code) - 1)) * (4 << (code % 4));
      wr(MAP[2*n+1], {16'h0, h, 8'h00}, 4'h3);
      wr(MAP[2*n], {24'h0, c}, 4'h1);
      repeat (2 * per) @(posedge aclk);
      measure(n, per, c[POL_BIT] ? act : per - act);
      // zero width keeps pin 0 low and stopped channel 1 idles low, so only the running bit is set
      if (code == 4) rd(STATUS_ADDR, 32'h1, RESP_OKAY);
      wr(MAP[2*n], {24'h0, c & 8'h7f}, 4'h1);
      pinchk(n);
    end
    // long reload period: silent first frame, then the frame average
    h = 8'($urandom);
    l = 8'($urandom);
    wr(WIDTH0_ADDR, {16'h0, h, l}, 4'h3);
    wr(CTRL0_ADDR, 32'hc8, 4'h1);
    measure(0, 16000, 0);
    repeat (600) @(posedge aclk);
    measure(0, 16384, 4 * (256 * (h % 16) + l));
    wr(CTRL0_ADDR, 32'h48, 4'h1);
    pinchk(0);
    rdm(STATUS_ADDR);
    end_of_test;
  end

  initial begin
    repeat (100000) @(posedge aclk);
    miscompares++;
    end_of_test;
  end
endmodule

bind dual_channel_pwm_unit pwm_unit_props i_pwm_unit_props (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pwm_out);
